// ---- core/clkgen_pkg.sv ----
// Constants for the clock generator control block
package clkgen_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int BASE_HZ = 307200;
  // Base clock period in pclk cycles, rounded down
  localparam int BASE_CYC = CLK_HZ / BASE_HZ;
  localparam int CORR_TICKS = 4;
  localparam int BAND_PCT = 15;
  // Error units: the fine band holds more than the maximum fine step count
  localparam logic [8:0] FINE_BAND = 9'h058;
  localparam logic [8:0] SETTLE_INIT = 9'h0ff;
  localparam logic [11:0] COARSE_STEP = 12'h020;
  localparam logic [11:0] FINE_STEP = 12'h001;
  localparam logic [8:0] COARSE_ERR = 9'h020;
  localparam logic [9:0] CAP_FIXED = 10'h180;
  localparam logic [9:0] CAP_NOMINAL = 10'h200;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [6:0] MULT_RST = 7'h15;
  localparam logic [11:0] LOOP_RST = 12'h000;
  localparam logic [12:0] STAB_XTAL = 13'h1000;
  localparam logic [12:0] STAB_EXT = 13'h0010;
  // Monitor windows in base ticks: base rate over least expected rate, plus one (plus two for the fast crystal window)
  localparam int XTAL_SLOW_HZ = 30000;
  localparam int XTAL_FAST_HZ = 1000000;
  localparam int EXT_SLOW_HZ = 60;
  localparam int EXT_FAST_HZ = 307200;
  localparam logic [12:0] WIN_XS = 13'(BASE_HZ / XTAL_SLOW_HZ + 1);
  localparam logic [12:0] WIN_XF = 13'(BASE_HZ / XTAL_FAST_HZ + 2);
  localparam logic [12:0] WIN_ES = 13'(BASE_HZ / EXT_SLOW_HZ + 1);
  localparam logic [12:0] WIN_EF = 13'(BASE_HZ / EXT_FAST_HZ + 1);
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MULT = 8'h04;
  localparam logic [7:0] OFF_TRIM = 8'h08;
  localparam logic [7:0] OFF_LOOP = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  // Control register bit positions
  localparam int B_EXT_ST = 0;
  localparam int B_EXT_ON = 1;
  localparam int B_INT_ST = 2;
  localparam int B_INT_ON = 3;
  localparam int B_CSEL = 4;
  localparam int B_MON_ON = 5;
  localparam int B_FLAG = 6;
  localparam int B_IRQ_EN = 7;
endpackage

// ---- core/clock_gen_lowpower_config.sv ----
// Clock generator control: loop filter, trim, stop handling, options
`timescale 1ns/1ns
`default_nettype none
module clock_gen_lowpower_config
  import clkgen_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_path_allow,
  input wire logic crystal_amp_allow,
  input wire logic low_freq_crystal,
  input wire logic osc_run_in_stop,
  input wire logic stop_in,
  input wire logic wait_in,
  input wire logic ext_clk_pin,
  output logic osc_output_clock,
  output logic bus_side_clock,
  output logic timebase_clock,
  output logic monitor_irq,
  output logic wake_request,
  output logic amp_drive,
  output logic amp_low_drive,
  output logic osc_in_is_port,
  output logic osc_out_is_port
);
  logic irq_en_reg, flag_reg, mon_on_reg, csel_reg, int_on_reg, ext_on_reg;
  logic int_st_reg, ext_st_reg, flag_seen_reg, dir_up_reg;
  logic irq_en_next, mon_on_next, csel_next, int_on_next, ext_on_next;
  logic [6:0] mult_reg;
  logic [7:0] trim_reg, base_len_reg;
  logic [9:0] cap_units_reg;
  logic [11:0] loop_word_reg;
  logic [8:0] err_reg;
  logic [1:0] corr_cnt_reg;
  logic [12:0] stab_cnt_reg, idle_cnt_reg, win;
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic halt, base_tick, corr, ext_edge, ext_dead, settle_kick;
  logic setup, wr_fire, rd_fire, ctrl_wr, addr_ok;
  logic [31:0] rd_word;
  logic [17:0] len_prod;

  // Static options feed straight in; they never change while running
  assign halt = stop_in & ~osc_run_in_stop;
  assign setup = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_fire = psel & penable & pready & ~pwrite;
  assign ctrl_wr = wr_fire && paddr == OFF_CTRL;
  assign settle_kick = halt | ~int_on_reg |
    (wr_fire && (paddr == OFF_MULT || paddr == OFF_TRIM));

  // APB slave, no wait states; answers are registered in the setup cycle
  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h00000000;
    case (paddr)
      OFF_CTRL: rd_word = {24'h000000, irq_en_reg, flag_reg, mon_on_reg,
        csel_reg, int_on_reg, int_st_reg, ext_on_reg, ext_st_reg};
      OFF_MULT: rd_word = {25'h0000000, mult_reg};
      OFF_TRIM: rd_word = {24'h000000, trim_reg};
      OFF_LOOP: rd_word = {20'h00000, loop_word_reg};
      OFF_STAT: rd_word = {18'h00000, cap_units_reg, osc_run_in_stop,
        low_freq_crystal, crystal_amp_allow, ext_path_allow};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
      prdata <= (setup && !pwrite) ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_reg <= MULT_RST;
      trim_reg <= TRIM_RST;
      dir_up_reg <= 1'b0;
    end else if (wr_fire && paddr == OFF_MULT) begin
      mult_reg <= pwdata[6:0];
      dir_up_reg <= pwdata[6:0] > mult_reg;
    end else if (wr_fire && paddr == OFF_TRIM) begin
      trim_reg <= pwdata[7:0];
      dir_up_reg <= pwdata[7:0] < trim_reg;
    end
  end

  // Capacitor size sets base period; more units, longer period
  assign len_prod = 18'(BASE_CYC) * {8'h00, cap_units_reg};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_units_reg <= CAP_NOMINAL;
      base_len_reg <= 8'(BASE_CYC);
    end else begin
      cap_units_reg <= CAP_FIXED + {2'b00, trim_reg};
      base_len_reg <= len_prod[16:9];
    end
  end

  // Base clock ceases entirely in halting stop
  tick_divider u_base (
    .clk(pclk),
    .rst_n(presetn),
    .run(int_on_reg & ~halt),
    .len(base_len_reg),
    .tick(base_tick)
  );

  assign corr = base_tick && corr_cnt_reg == 2'(CORR_TICKS - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_cnt_reg <= 2'b00;
    end else if (base_tick) begin
      corr_cnt_reg <= corr_cnt_reg + 2'b01;
    end
  end

  // Loop filter: coarse steps outside the band, single-unit steps inside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= SETTLE_INIT;
      loop_word_reg <= LOOP_RST;
    end else if (settle_kick) begin
      // Loop word frozen across stop; only the error is re-armed
      err_reg <= SETTLE_INIT;
    end else if (corr && err_reg > FINE_BAND) begin
      err_reg <= err_reg - COARSE_ERR;
      loop_word_reg <= dir_up_reg ? loop_word_reg + COARSE_STEP
                                  : loop_word_reg - COARSE_STEP;
    end else if (corr && err_reg != 9'h000) begin
      err_reg <= err_reg - 9'h001;
      loop_word_reg <= dir_up_reg ? loop_word_reg + FINE_STEP
                                  : loop_word_reg - FINE_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_st_reg <= 1'b0;
    end else if (settle_kick) begin
      int_st_reg <= 1'b0;
    end else if (err_reg <= FINE_BAND) begin
      int_st_reg <= 1'b1;
    end
  end

  // External clock pin: two-flop synchroniser, then edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_clk_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end
  assign ext_edge = ext_s2_reg & ~ext_s3_reg;

  // Stabilization divider counts external edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_reg <= 13'h0000;
      ext_st_reg <= 1'b0;
    end else if (halt || !ext_on_reg) begin
      stab_cnt_reg <= 13'h0000;
      ext_st_reg <= 1'b0;
    end else if (ext_edge && !ext_st_reg) begin
      stab_cnt_reg <= stab_cnt_reg + 13'h0001;
      if (stab_cnt_reg + 13'h0001 >= (crystal_amp_allow ? STAB_XTAL : STAB_EXT)) begin
        ext_st_reg <= 1'b1;
      end
    end
  end

  // Monitor window; pclk cannot see the upper range limits
  always_comb begin
    if (crystal_amp_allow) begin
      win = low_freq_crystal ? WIN_XS : WIN_XF;
    end else begin
      win = low_freq_crystal ? WIN_ES : WIN_EF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_reg <= 13'h0000;
    end else if (ext_edge || !mon_on_reg) begin
      idle_cnt_reg <= 13'h0000;
    end else if (base_tick && !ext_dead) begin
      idle_cnt_reg <= idle_cnt_reg + 13'h0001;
    end
  end
  assign ext_dead = idle_cnt_reg >= win;

  // Control bit interlocks; forced states override software writes
  always_comb begin
    irq_en_next = irq_en_reg;
    mon_on_next = mon_on_reg;
    csel_next = csel_reg;
    int_on_next = int_on_reg;
    ext_on_next = ext_on_reg;
    if (ctrl_wr) begin
      if (!pwdata[B_MON_ON] || (int_st_reg && ext_st_reg)) begin
        mon_on_next = pwdata[B_MON_ON];
      end
      if (!pwdata[B_IRQ_EN] || mon_on_reg) begin
        irq_en_next = pwdata[B_IRQ_EN];
      end
      if (pwdata[B_CSEL] ? ext_st_reg : int_st_reg) begin
        csel_next = pwdata[B_CSEL];
      end
      if (pwdata[B_INT_ON] || (csel_reg && !mon_on_reg)) begin
        int_on_next = pwdata[B_INT_ON];
      end
      ext_on_next = pwdata[B_EXT_ON];
    end
    if (mon_on_reg || !csel_reg) begin
      int_on_next = 1'b1;
    end
    if (!ext_path_allow) begin
      ext_on_next = 1'b0;
    end
    if (flag_reg) begin
      mon_on_next = 1'b1;
    end
    if (!int_on_next || !ext_on_next || halt) begin
      mon_on_next = 1'b0;
    end
    if (!mon_on_next) begin
      irq_en_next = 1'b0;
    end
    if (!int_on_next) begin
      csel_next = 1'b1;
    end
    if (!ext_on_next) begin
      csel_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= 1'b0;
      mon_on_reg <= 1'b0;
      csel_reg <= 1'b0;
      int_on_reg <= 1'b1;
      ext_on_reg <= 1'b0;
    end else begin
      irq_en_reg <= irq_en_next;
      mon_on_reg <= mon_on_next;
      csel_reg <= csel_next;
      int_on_reg <= int_on_next;
      ext_on_reg <= ext_on_next;
    end
  end

  // Flag clears by read-while-set then write of zero; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
      flag_seen_reg <= 1'b0;
    end else if (!mon_on_reg || halt) begin
      flag_reg <= 1'b0;
      flag_seen_reg <= 1'b0;
    end else if (ext_dead) begin
      flag_reg <= 1'b1;
    end else if (ctrl_wr && flag_seen_reg && !pwdata[B_FLAG]) begin
      flag_reg <= 1'b0;
      flag_seen_reg <= 1'b0;
    end else if (rd_fire && paddr == OFF_CTRL && flag_reg) begin
      flag_seen_reg <= 1'b1;
    end
  end

  // Clocks only change toward low when stopped, so no runt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_output_clock <= 1'b0;
      bus_side_clock <= 1'b0;
      timebase_clock <= 1'b0;
    end else begin
      osc_output_clock <= ~halt & ~osc_output_clock;
      if (halt) begin
        bus_side_clock <= 1'b0;
        timebase_clock <= 1'b0;
      end else begin
        bus_side_clock <= bus_side_clock ^ osc_output_clock;
        timebase_clock <= timebase_clock ^ base_tick;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_irq <= 1'b0;
      wake_request <= 1'b0;
      amp_drive <= 1'b0;
      amp_low_drive <= 1'b0;
      osc_in_is_port <= 1'b1;
      osc_out_is_port <= 1'b1;
    end else begin
      monitor_irq <= irq_en_reg & flag_reg;
      wake_request <= wait_in & ~stop_in & irq_en_reg & flag_reg;
      amp_drive <= crystal_amp_allow & ext_path_allow & ext_on_reg;
      amp_low_drive <= low_freq_crystal;
      osc_in_is_port <= ~(ext_path_allow & ext_on_reg);
      osc_out_is_port <= ~(crystal_amp_allow & ext_path_allow & ext_on_reg);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_band_flag: assert property (int_st_reg |-> err_reg <= FINE_BAND)
    else $error("stable flag outside band");
  a_fine_step: assert property (corr && !settle_kick && err_reg <= FINE_BAND
    && err_reg != 9'h000 |=> err_reg == $past(err_reg) - 9'h001)
    else $error("fine step not one unit");
  a_fine_bound: assert property ($fell(int_st_reg) |-> ##[0:3] err_reg == SETTLE_INIT)
    else $error("fine walk not re-armed");
  a_cap_size: assert property (##1 cap_units_reg == CAP_FIXED + {2'b00, $past(trim_reg)})
    else $error("capacitor units wrong");
  a_halt_clocks: assert property (halt[*2] |-> !osc_output_clock && !bus_side_clock)
    else $error("clocks not low in stop");
  a_halt_flags: assert property (halt |=> !int_st_reg && !ext_st_reg)
    else $error("stable flags kept in stop");
  a_halt_mon: assert property (halt |=> !mon_on_reg ##1 !irq_en_reg && !flag_reg)
    else $error("monitor kept in stop");
  a_ext_gate: assert property (!ext_path_allow |=> !ext_on_reg)
    else $error("external enable set without option");
  a_amp_drive: assert property (amp_drive |-> $past(crystal_amp_allow && ext_on_reg))
    else $error("amplifier drives wrongly");
  a_irq_out: assert property (irq_en_reg && flag_reg |=> monitor_irq)
    else $error("interrupt missing");
  a_stop_wake: assert property (stop_in |=> !wake_request)
    else $error("woke from stop");

  c_settle: cover property ($rose(int_st_reg));
  c_ext_stable: cover property ($rose(ext_st_reg));
  c_mon_flag: cover property ($rose(flag_reg) ##[1:50] monitor_irq);
  c_halt_resume: cover property ($fell(halt) ##[1:20] osc_output_clock);
endmodule
`default_nettype wire

// ---- core/tick_divider.sv ----
// Programmable divider giving one-cycle tick pulses
`timescale 1ns/1ns
`default_nettype none
module tick_divider
  import clkgen_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] len,
  output logic tick
);
  logic [7:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_reg + 8'h01 >= len) begin
      cnt_reg <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/clock_gen_lowpower_config_bench.sv ----
// Bench for the clock generator control block
`timescale 1ns/1ns
`default_nettype none
module clock_gen_lowpower_config_bench
  import clkgen_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic ext_path_allow, crystal_amp_allow, low_freq_crystal, osc_run_in_stop;
  logic stop_in, wait_in, ext_clk_pin, osc_run;
  logic osc_output_clock, bus_side_clock, timebase_clock, monitor_irq, wake_request;
  logic amp_drive, amp_low_drive, osc_in_is_port, osc_out_is_port;
  int n_errors, compares, edges;

  clock_gen_lowpower_config dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_path_allow, .crystal_amp_allow, .low_freq_crystal,
    .osc_run_in_stop, .stop_in, .wait_in, .ext_clk_pin, .osc_output_clock,
    .bus_side_clock, .timebase_clock, .monitor_irq, .wake_request, .amp_drive,
    .amp_low_drive, .osc_in_is_port, .osc_out_is_port
  );
  ext_osc_model osc_u (.run(osc_run), .osc_pin(ext_clk_pin));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge ext_clk_pin) edges <= edges + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d, n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Entered just after a rising edge; idles one cycle after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_ctrl(input int b);
    do begin
      apb(1'b0, OFF_CTRL, 32'h0);
    end while (rdv[b] !== 1'b1);
  endtask

  task automatic do_reset(input logic [3:0] opt);
    {osc_run_in_stop, low_freq_crystal, crystal_amp_allow, ext_path_allow} <= opt;
    stop_in <= 1'b0;
    wait_in <= 1'b0;
    osc_run <= 1'b0;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic ones(output int k);
    k = 0;
    repeat (4) begin
      @(posedge pclk);
      k += int'(osc_output_clock);
    end
  endtask

  task automatic measure(output int p);
    p = 0;
    @(posedge timebase_clock);
    @(posedge pclk);
    while (timebase_clock !== 1'b0) begin
      @(posedge pclk);
      p++;
    end
  endtask

  task automatic t_defaults();
    int p_hi, p_lo;
    do_reset(4'h0);
    apb(1'b0, OFF_CTRL, 32'h0);
    check(rdv, 32'h08, "ctrl reset");
    apb(1'b0, OFF_TRIM, 32'h0);
    check(rdv, 32'h80, "trim reset");
    apb(1'b0, OFF_STAT, 32'h0);
    check(rdv, 32'h2000, "stat reset");
    apb(1'b1, 8'h14, 32'h55);
    check(32'(perr), 32'h1, "unmapped error");
    apb(1'b1, OFF_CTRL, 32'h0a);
    apb(1'b0, OFF_CTRL, 32'h0);
    check(32'(rdv[B_EXT_ON]), 32'h0, "ext on locked");
    check({30'h0, osc_in_is_port, osc_out_is_port}, 32'h3, "port pins");
    check(32'(amp_drive), 32'h0, "amp off");
    wait_ctrl(B_INT_ST);
    check(32'(rdv[B_INT_ST]), 32'h1, "int stable");
    apb(1'b1, OFF_TRIM, 32'hff);
    apb(1'b0, OFF_STAT, 32'h0);
    check(32'(rdv[13:4]), 32'd639, "cap max");
    measure(p_hi);
    measure(p_hi);
    apb(1'b1, OFF_TRIM, 32'h00);
    apb(1'b0, OFF_STAT, 32'h0);
    check(32'(rdv[13:4]), 32'd384, "cap min");
    measure(p_lo);
    measure(p_lo);
    check(32'(p_hi > p_lo), 32'h1, "trim slows base");
  endtask

  task automatic t_crystal();
    int n, k;
    do_reset(4'h3);
    osc_run <= 1'b1;
    wait_ctrl(B_INT_ST);
    apb(1'b1, OFF_CTRL, 32'h0a);
    edges = 0;
    wait_ctrl(B_EXT_ST);
    n = int'(STAB_XTAL);
    check(32'(edges >= n - 1 && edges <= n + 4), 32'h1, "xtal settle");
    check({29'h0, amp_drive, osc_out_is_port, osc_in_is_port}, 32'h4, "amp on");
    check(32'(amp_low_drive), 32'h0, "fast drive");
    apb(1'b1, OFF_CTRL, 32'h2a);
    apb(1'b1, OFF_CTRL, 32'haa);
    osc_run <= 1'b0;
    n = 0;
    while (monitor_irq !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    // Fast crystal window is two base ticks; a slow window would take far longer
    check(32'(n < 400), 32'h1, "monitor window");
    apb(1'b0, OFF_CTRL, 32'h0);
    check(32'(rdv[7:6]), 32'h3, "flag and enable");
    check(32'(monitor_irq), 32'h1, "monitor irq");
    wait_in <= 1'b1;
    repeat (2) @(posedge pclk);
    check(32'(wake_request), 32'h1, "wake from wait");
    stop_in <= 1'b1;
    repeat (3) @(posedge pclk);
    repeat (8) begin
      @(posedge pclk);
      check({29'h0, osc_output_clock, bus_side_clock, timebase_clock}, 32'h0,
        "halted clocks");
    end
    check(32'(monitor_irq), 32'h0, "irq in stop");
    stop_in <= 1'b0;
    wait_in <= 1'b0;
    ones(k);
    check(k, 32'h2, "clock resumes");
    apb(1'b0, OFF_CTRL, 32'h0);
    check(rdv, 32'h0a, "ctrl after stop");
    apb(1'b0, OFF_MULT, 32'h0);
    check(rdv, 32'h15, "mult kept");
    apb(1'b0, OFF_TRIM, 32'h0);
    check(rdv, 32'h80, "trim kept");
  endtask

  task automatic t_ext();
    int n, k;
    do_reset(4'hd);
    osc_run <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h0a);
    edges = 0;
    wait_ctrl(B_EXT_ST);
    n = int'(STAB_EXT);
    check(32'(edges >= n - 1 && edges <= n + 4), 32'h1, "ext settle");
    check({30'h0, amp_drive, osc_out_is_port}, 32'h1, "no crystal amp");
    check(32'(amp_low_drive), 32'h1, "low drive");
    apb(1'b0, OFF_STAT, 32'h0);
    check(32'(rdv[3:0]), 32'hd, "options");
    stop_in <= 1'b1;
    wait_in <= 1'b1;
    repeat (2) @(posedge pclk);
    ones(k);
    check(k, 32'h2, "clock in stop");
    check(32'(wake_request), 32'h0, "no wake in stop");
    apb(1'b0, OFF_CTRL, 32'h0);
    check(32'(rdv[B_EXT_ST]), 32'h1, "stable kept");
  endtask

  initial begin
    {presetn, psel, penable, pwrite, stop_in, wait_in, osc_run} = 7'h0;
    {ext_path_allow, crystal_amp_allow, low_freq_crystal, osc_run_in_stop} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    compares = 0;
    @(posedge pclk);
    t_defaults();
    t_crystal();
    t_ext();
    conclude();
  end

  // Whole run needs well under half of this span
  initial begin
    #(40 * 90000);
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire

// ---- testbench/ext_osc_model.sv ----
// External clock source on the oscillator input pin
`timescale 1ns/1ns
`default_nettype none
module ext_osc_model #(
  parameter int HALF_NS = 62
) (
  input wire logic run,
  output logic osc_pin
);
  // Stands still low while stopped, like a source that has been removed
  initial osc_pin = 1'b0;
  always begin
    #(HALF_NS);
    osc_pin = run ? ~osc_pin : 1'b0;
  end
endmodule
`default_nettype wire
